// *** dv/eid_ext_dev.sv ***
// Model of the outside devices that drive the eight interrupt pins.
// Assumes the bench calls its tasks; idle pins rest high as with pull-ups.
`timescale 1ns/1ps
module eid_ext_dev (
  // Clock
  input wire logic pclk,
  // Pin levels
  output logic [7:0] ext_irq_pin
);
  initial ext_irq_pin = 8'hff;

  // Change one pin just after a rising edge
  task automatic set_pin(input int idx, input logic val);
    @(posedge pclk);
    ext_irq_pin[idx] <= val;
  endtask

  // Hold the pins for a number of cycles
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the external interrupt detector.
// Assumes the detector's APB slave and the pin model in eid_ext_dev.
`timescale 1ns/1ps
module tb_top;
  import eid_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] ext_irq_pin, irq_req;
  logic standby_deep, osc_keeping_standby, hold_release, halt_on_rc;
  logic t2_count, t3_count, t2l_capture, t2h_capture;
  logic [1:0] md;
  logic pol, lv, ex;
  int mismatches, n_checks, cyc, p;
  int cnt [4];
  // Pin 2 table: mode, polarity, start level, flag after one toggle
  localparam logic [4:0] MTAB [9] = '{5'h02, 5'h0b, 5'h0d, 5'h10, 5'h13, 5'h16, 5'h15,
                                       5'h1d, 5'h1b};
  localparam logic [31:0] RTAB [4] = '{32'h0000_0001, 32'h0000_000c, 32'h0000_0050,
                                        32'h0000_0380};
  localparam int PTAB [4] = '{2, 5, 4, 5};

  eid_top i_eid_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_pin(ext_irq_pin), .standby_deep(standby_deep),
    .osc_keeping_standby(osc_keeping_standby), .irq_req(irq_req),
    .hold_release(hold_release), .halt_on_rc(halt_on_rc), .t2_count(t2_count),
    .t3_count(t3_count), .t2l_capture(t2l_capture), .t2h_capture(t2h_capture)
  );
  eid_ext_dev i_eid_ext_dev (.pclk(pclk), .ext_irq_pin(ext_irq_pin));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Event counters and hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    cnt[0] <= cnt[0] + int'(t2_count === 1'b1);
    cnt[1] <= cnt[1] + int'(t3_count === 1'b1);
    cnt[2] <= cnt[2] + int'(t2l_capture === 1'b1);
    cnt[3] <= cnt[3] + int'(t2h_capture === 1'b1);
    if (cyc > 20000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; waits for pready with a bounded count
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      mismatches++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Mode and enable of one pin; partner pin and both flags written 0
  task automatic set_mode(input int pn, input logic [1:0] m, input logic en);
    logic [31:0] d;
    d = (pn % 2) ? {24'h00_0000, m, 1'b0, en, 4'h0} : {24'h00_0000, 4'h0, m, 1'b0, en};
    apb(1'b1, ADDR_CTRL_01 + 32'(4 * (pn / 2)), d);
  endtask

  task automatic clr_cnt;
    @(negedge pclk);
    cnt = '{0, 0, 0, 0};
  endtask

  initial begin
    {presetn, psel, penable, pwrite, standby_deep, osc_keeping_standby} = 6'h00;
    {paddr, pwdata, cyc, mismatches, n_checks} = '0;
    pstrb = 4'hf;
    cnt = '{0, 0, 0, 0};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      apb(1'b0, ADDR_CTRL_01 + 32'(4 * r), 32'h0000_0000);
      chk(rd, 32'h0000_0000, "ctrl reset");
    end
    apb(1'b0, 32'h0000_0100, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001, "unmapped");
    apb(1'b0, 32'hfffe_ff63, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001, "misaligned");
    chk(rd, 32'h0000_0000, "refused read data");
    apb(1'b1, ADDR_CTRL_67, 32'h0000_00dd);
    apb(1'b0, ADDR_CTRL_67, 32'h0000_0000);
    chk(rd, 32'h0000_00dd, "ctrl layout");
    // Byte lanes: lane 0 off keeps a control byte, lane 1 off keeps route bits 9:8
    pstrb <= 4'he;
    apb(1'b1, ADDR_CTRL_67, 32'hffff_ff00);
    pstrb <= 4'h1;
    apb(1'b1, ADDR_ROUTE, 32'h0000_03ff);
    pstrb <= 4'hf;
    apb(1'b0, ADDR_CTRL_67, 32'h0000_0000);
    chk(rd, 32'h0000_00dd, "lane 0 off");
    apb(1'b0, ADDR_ROUTE, 32'h0000_0000);
    chk(rd, 32'h0000_00ff, "lane 1 off");
    apb(1'b1, ADDR_ROUTE, 32'h0000_0000);
    // Falling edge on pin 0, flag stays until software clears it
    set_mode(0, MODE_FALL, 1'b1);
    i_eid_ext_dev.set_pin(0, 1'b0);
    i_eid_ext_dev.wait_cyc(6);
    chk({24'h00_0000, irq_req}, 32'h0000_0001, "irq pin0");
    i_eid_ext_dev.set_pin(0, 1'b1);
    i_eid_ext_dev.wait_cyc(6);
    apb(1'b0, ADDR_CTRL_01, 32'h0000_0000);
    chk(rd, 32'h0000_000b, "flag held");
    set_mode(0, MODE_FALL, 1'b1);
    i_eid_ext_dev.wait_cyc(3);
    apb(1'b0, ADDR_CTRL_01, 32'h0000_0000);
    chk(rd, 32'h0000_0009, "flag cleared");
    chk({24'h00_0000, irq_req}, 32'h0000_0000, "irq off");
    // Clearing write while a low level keeps detecting: the flag survives
    set_mode(0, MODE_LEVEL, 1'b0);
    i_eid_ext_dev.set_pin(0, 1'b0);
    i_eid_ext_dev.wait_cyc(4);
    set_mode(0, MODE_LEVEL, 1'b0);
    apb(1'b0, ADDR_CTRL_01, 32'h0000_0000);
    chk(rd, 32'h0000_0006, "set beats clear");
    i_eid_ext_dev.set_pin(0, 1'b1);
    set_mode(0, MODE_OFF, 1'b0);
    // Every mode on pin 2; modes 01 to 11 with both polarities, mode 00 with polarity 0 only
    for (int k = 0; k < 9; k++) begin
      {md, pol, lv, ex} = MTAB[k];
      i_eid_ext_dev.set_pin(2, lv);
      apb(1'b1, ADDR_POLARITY, {29'h0000_0000, pol, 2'b00});
      set_mode(2, md, 1'b0);
      i_eid_ext_dev.wait_cyc(4);
      set_mode(2, md, 1'b0);
      apb(1'b0, ADDR_CTRL_23, 32'h0000_0000);
      chk(rd, {28'h000_0000, md, 2'b00}, "before toggle");
      i_eid_ext_dev.set_pin(2, !lv);
      i_eid_ext_dev.wait_cyc(6);
      apb(1'b0, ADDR_CTRL_23, 32'h0000_0000);
      chk(rd, {28'h000_0000, md, ex, 1'b0}, "after toggle");
    end
    apb(1'b1, ADDR_POLARITY, 32'h0000_0000);
    // Timer counts and captures: edges, then a held level
    for (int k = 0; k < 4; k++) begin
      p = PTAB[k];
      i_eid_ext_dev.set_pin(p, 1'b1);
      apb(1'b1, ADDR_ROUTE, RTAB[k]);
      set_mode(p, MODE_FALL, 1'b0);
      i_eid_ext_dev.wait_cyc(4);
      clr_cnt();
      repeat (2) begin
        i_eid_ext_dev.set_pin(p, 1'b0);
        i_eid_ext_dev.wait_cyc(3);
        i_eid_ext_dev.set_pin(p, 1'b1);
        i_eid_ext_dev.wait_cyc(3);
      end
      i_eid_ext_dev.wait_cyc(3);
      chk(32'(cnt[k]), 32'h0000_0002, "edge count");
      chk(32'(cnt[0] + cnt[1] + cnt[2] + cnt[3]), 32'h0000_0002, "stray");
      set_mode(p, MODE_LEVEL, 1'b0);
      clr_cnt();
      i_eid_ext_dev.set_pin(p, 1'b0);
      i_eid_ext_dev.wait_cyc(20);
      i_eid_ext_dev.set_pin(p, 1'b1);
      i_eid_ext_dev.wait_cyc(5);
      chk(32'(cnt[k] >= 9 && cnt[k] <= 11), 32'h0000_0001, "level repeat");
    end
    apb(1'b1, ADDR_ROUTE, 32'h0000_0000);
    // Standby: pin 7 falling mode entered low, pin 6 both edges
    i_eid_ext_dev.set_pin(7, 1'b0);
    i_eid_ext_dev.wait_cyc(4);
    apb(1'b1, ADDR_CTRL_67, 32'h0000_009d);
    @(posedge pclk);
    standby_deep <= 1'b1;
    i_eid_ext_dev.wait_cyc(3);
    i_eid_ext_dev.set_pin(7, 1'b1);
    i_eid_ext_dev.wait_cyc(4);
    i_eid_ext_dev.set_pin(7, 1'b0);
    i_eid_ext_dev.wait_cyc(6);
    chk({31'h0000_0000, hold_release}, 32'h0000_0000, "blocked edge");
    i_eid_ext_dev.set_pin(6, 1'b0);
    i_eid_ext_dev.wait_cyc(6);
    chk({30'h0000_0000, hold_release, halt_on_rc}, 32'h0000_0003, "deep wake");
    apb(1'b0, ADDR_CTRL_67, 32'h0000_0000);
    chk(rd, 32'h0000_009f, "flags in standby");
    // Status: standby bit, pin 6 request, pins 6 and 7 low
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0001_403f, "status");
    @(posedge pclk);
    standby_deep <= 1'b0;
    osc_keeping_standby <= 1'b1;
    i_eid_ext_dev.wait_cyc(3);
    chk({30'h0000_0000, hold_release, halt_on_rc}, 32'h0000_0002, "osc wake");
    apb(1'b1, ADDR_CTRL_67, 32'h0000_0005);
    i_eid_ext_dev.wait_cyc(4);
    apb(1'b0, ADDR_CTRL_67, 32'h0000_0000);
    chk(rd, 32'h0000_0007, "level in standby");
    chk({31'h0000_0000, hold_release}, 32'h0000_0001, "level wake");
    @(posedge pclk);
    osc_keeping_standby <= 1'b0;
    i_eid_ext_dev.wait_cyc(3);
    chk({31'h0000_0000, hold_release}, 32'h0000_0000, "no standby");
    end_sim();
  end
endmodule

// *** rtl/eid_pkg.sv ***
// Constants for the eight-input external interrupt detector.
// Assumes a 250 MHz APB clock and a 32-bit APB bus with word-aligned registers.
package eid_pkg;

  // Clock and pacing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TCYC_NS = 4;
  localparam int REPEAT_TCYC = 2;
  localparam int REPEAT_RAW = (REPEAT_TCYC * TCYC_NS) / CLK_PERIOD_NS;
  localparam int REPEAT_CYCLES = (REPEAT_RAW < 1) ? 1 : REPEAT_RAW;
  localparam int REP_CNT_W = 4;
  localparam logic [REP_CNT_W-1:0] REP_LAST = REP_CNT_W'(REPEAT_CYCLES - 1);

  // Register indices; byte address is four times the index
  localparam logic [31:0] IDX_CTRL_01 = 32'h0000_7fd8;
  localparam logic [31:0] IDX_CTRL_23 = 32'h0000_7fd9;
  localparam logic [31:0] IDX_CTRL_45 = 32'h0000_7fda;
  localparam logic [31:0] IDX_CTRL_67 = 32'h0000_7fdb;
  localparam logic [31:0] IDX_POLARITY = 32'h0000_7fdc;
  localparam logic [31:0] IDX_ROUTE = 32'h0000_7fdd;
  localparam logic [31:0] IDX_STATUS = 32'h0000_7fde;
  localparam logic [31:0] ADDR_CTRL_01 = {IDX_CTRL_01[29:0], 2'b00};
  localparam logic [31:0] ADDR_CTRL_23 = {IDX_CTRL_23[29:0], 2'b00};
  localparam logic [31:0] ADDR_CTRL_45 = {IDX_CTRL_45[29:0], 2'b00};
  localparam logic [31:0] ADDR_CTRL_67 = {IDX_CTRL_67[29:0], 2'b00};
  localparam logic [31:0] ADDR_POLARITY = {IDX_POLARITY[29:0], 2'b00};
  localparam logic [31:0] ADDR_ROUTE = {IDX_ROUTE[29:0], 2'b00};
  localparam logic [31:0] ADDR_STATUS = {IDX_STATUS[29:0], 2'b00};

  // Control register fields
  localparam int UPPER_MODE_LSB = 6;
  localparam int UPPER_FLAG_BIT = 5;
  localparam int UPPER_EN_BIT = 4;
  localparam int LOWER_MODE_LSB = 2;
  localparam int LOWER_FLAG_BIT = 1;
  localparam int LOWER_EN_BIT = 0;

  // Detection modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_LEVEL = 2'h1;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_BOTH = 2'h3;

  // Route register fields
  localparam int ROUTE_W = 10;
  localparam int RT_T2_EN = 0;
  localparam int RT_T2_SEL = 1;
  localparam int RT_T3_EN = 2;
  localparam int RT_T3_SEL = 3;
  localparam int RT_CAPL_EN = 4;
  localparam int RT_CAPL_LSB = 5;
  localparam int RT_CAPH_EN = 7;
  localparam int RT_CAPH_LSB = 8;

  // Status register fields
  localparam int ST_PIN_LSB = 0;
  localparam int ST_REQ_LSB = 8;
  localparam int ST_STANDBY_BIT = 16;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] POLARITY_RESET = 8'h00;
  localparam logic [ROUTE_W-1:0] ROUTE_RESET = 10'h000;

endpackage

// *** rtl/eid_top.sv ***
// External interrupt detector: eight pins, four control registers, timer event outputs.
// Assumes asynchronous pins (two-stage synchroniser inside), an APB master, and a standby controller.
//
// Notes on behaviour
// - Each pin detects low level, high level, falling, rising or both edges; sets flag.
// - Pin 2 or 3 as timer 2 source gives one count per flag-setting change.
// - Level-mode timer 2 source counts every two instruction cycles while level holds.
// - One of pins 0, 2, 4, 5 strobes timer 2L capture per flag-setting change.
// - Level-mode timer 2L capture source repeats its strobe every two instruction cycles.
// - One of pins 1, 3, 4, 5 strobes timer 2H capture per flag-setting change.
// - Level-mode timer 2H capture source repeats its strobe every two instruction cycles.
// - Pin 4 or 5 as timer 3 source gives one count per flag-setting change.
// - Level-mode timer 3 source counts every two instruction cycles while level holds.
// - Flag and enable in deep standby release to halt on the RC oscillator.
// - Flag and enable in oscillator-keeping standby release to halt on the kept oscillator.
// - The CPU leaves halt for normal run once the request is accepted.
// - In deep standby a level-mode pin still sets its flag and releases standby.
// - In oscillator-keeping standby a level-mode pin sets its flag and releases standby.
// - In standby, edges back toward the entry level do not set the flag.
// - Each control byte: upper pin mode 7:6, flag 5, enable 4; lower 3:2, 1, 0.
// - All four control registers reset to zero.
// - Mode 00 off, 01 low level, 10 falling, 11 both; inversion swaps polarity.
// - Flag and enable together raise that pin's own interrupt request.
`timescale 1ns/1ps
module eid_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt pins
  input wire logic [7:0] ext_irq_pin,
  // Standby state from the power controller
  input wire logic standby_deep,
  input wire logic osc_keeping_standby,
  // Requests and release
  output logic [7:0] irq_req,
  output logic hold_release,
  output logic halt_on_rc,
  // Timer events
  output logic t2_count,
  output logic t3_count,
  output logic t2l_capture,
  output logic t2h_capture
);
  import eid_pkg::*;

  // Picks one of four pin numbers by a two-bit selector
  function automatic logic [2:0] pick4(input logic [1:0] sel, input logic [2:0] a,
                                       input logic [2:0] b, input logic [2:0] c,
                                       input logic [2:0] d);
    logic [2:0] r;
    r = a;
    case (sel)
      2'h0: r = a;
      2'h1: r = b;
      2'h2: r = c;
      default: r = d;
    endcase
    return r;
  endfunction

  // Control field of one pin taken from a control byte
  function automatic logic [3:0] pin_field(input logic [7:0] byte_in, input logic upper);
    logic [3:0] r;
    if (upper) begin
      r = {byte_in[UPPER_MODE_LSB +: 2], byte_in[UPPER_FLAG_BIT], byte_in[UPPER_EN_BIT]};
    end else begin
      r = {byte_in[LOWER_MODE_LSB +: 2], byte_in[LOWER_FLAG_BIT], byte_in[LOWER_EN_BIT]};
    end
    return r;
  endfunction

  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] pin_prev;
  logic [7:0] entry_lvl;
  logic standby_prev;
  logic [1:0] mode [8];
  logic [7:0] flag;
  logic [7:0] en;
  logic [7:0] inv;
  logic [ROUTE_W-1:0] route;
  logic [REP_CNT_W-1:0] rep_cnt;
  logic [7:0] next_flag;

  // Standby tracking
  wire standby_any = standby_deep | osc_keeping_standby;
  wire standby_entry = standby_any & ~standby_prev;
  wire [7:0] entry_ref = standby_entry ? pin_prev : entry_lvl;
  wire [7:0] edge_ok = standby_any ? ~(pin_prev ^ entry_ref) : 8'hff;

  // Polarity-corrected levels
  wire [7:0] lvl = pin_sync ^ inv;
  wire [7:0] prev_lvl = pin_prev ^ inv;
  wire rep_en = (rep_cnt == '0);

  wire [7:0] lvl_act;
  wire [7:0] edge_evt;
  wire [7:0] set_evt;
  wire [7:0] cnt_evt;
  wire [7:0] req_now = flag & en;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_det
      assign lvl_act[gi] = (mode[gi] == MODE_LEVEL) & ~lvl[gi];
      assign edge_evt[gi] = edge_ok[gi] &
                            (((mode[gi] == MODE_FALL) & prev_lvl[gi] & ~lvl[gi]) |
                             ((mode[gi] == MODE_BOTH) & (pin_prev[gi] ^ pin_sync[gi])));
      assign set_evt[gi] = edge_evt[gi] | lvl_act[gi];
      assign cnt_evt[gi] = edge_evt[gi] | (lvl_act[gi] & rep_en);
    end
  endgenerate

  // APB decode
  wire acc_first = psel & penable & ~pready;
  wire wr_done = psel & penable & pready & pwrite & ~pslverr;
  wire [31:0] addr_word = {paddr[31:2], 2'b00};
  wire hit_c01 = (addr_word == ADDR_CTRL_01);
  wire hit_c23 = (addr_word == ADDR_CTRL_23);
  wire hit_c45 = (addr_word == ADDR_CTRL_45);
  wire hit_c67 = (addr_word == ADDR_CTRL_67);
  wire hit_pol = (addr_word == ADDR_POLARITY);
  wire hit_rte = (addr_word == ADDR_ROUTE);
  wire hit_sts = (addr_word == ADDR_STATUS);
  wire addr_hit = (paddr[1:0] == 2'b00) &
                  (hit_c01 | hit_c23 | hit_c45 | hit_c67 | hit_pol | hit_rte | hit_sts);
  wire wr_lo = wr_done & pstrb[0];
  wire wr_hi = wr_done & pstrb[1];
  wire [3:0] wr_ctrl = {4{wr_lo}} & {hit_c67, hit_c45, hit_c23, hit_c01};

  // Control bytes as read back
  wire [7:0] ctrl_rd [4];
  generate
    for (gi = 0; gi < 4; gi++) begin : g_rd
      assign ctrl_rd[gi] = {mode[2*gi+1], flag[2*gi+1], en[2*gi+1],
                            mode[2*gi], flag[2*gi], en[2*gi]};
    end
  endgenerate

  wire [31:0] status_rd = {15'h0000, standby_any, req_now, pin_sync};
  wire [31:0] rd_data = hit_c01 ? {24'h00_0000, ctrl_rd[0]} :
                        hit_c23 ? {24'h00_0000, ctrl_rd[1]} :
                        hit_c45 ? {24'h00_0000, ctrl_rd[2]} :
                        hit_c67 ? {24'h00_0000, ctrl_rd[3]} :
                        hit_pol ? {24'h00_0000, inv} :
                        hit_rte ? {22'h00_0000, route} :
                        status_rd;

  // Flag update: detection wins over a clearing write
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      wire [3:0] wfield = pin_field(pwdata[7:0], (gi % 2) == 1);
      assign next_flag[gi] = set_evt[gi] |
                             (wr_ctrl[gi/2] ? wfield[1] : flag[gi]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mode[gi] <= MODE_OFF;
          en[gi] <= 1'b0;
        end else if (wr_ctrl[gi/2]) begin
          mode[gi] <= wfield[3:2];
          en[gi] <= wfield[0];
        end
      end
    end
  endgenerate

  // Timer event source selection
  wire [2:0] t2_src = route[RT_T2_SEL] ? 3'd3 : 3'd2;
  wire [2:0] t3_src = route[RT_T3_SEL] ? 3'd5 : 3'd4;
  wire [2:0] capl_src = pick4(route[RT_CAPL_LSB +: 2], 3'd0, 3'd2, 3'd4, 3'd5);
  wire [2:0] caph_src = pick4(route[RT_CAPH_LSB +: 2], 3'd1, 3'd3, 3'd4, 3'd5);

  // Pin synchroniser and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
      pin_prev <= 8'h00;
    end else begin
      pin_meta <= ext_irq_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Pin levels held from standby entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_prev <= 1'b0;
      entry_lvl <= 8'h00;
    end else begin
      standby_prev <= standby_any;
      if (standby_entry) begin
        entry_lvl <= pin_prev;
      end
    end
  end

  // Flags, polarity and route registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= CTRL_RESET;
      inv <= POLARITY_RESET;
      route <= ROUTE_RESET;
    end else begin
      flag <= next_flag;
      if (wr_lo && hit_pol) begin
        inv <= pwdata[7:0];
      end
      if (hit_rte && wr_lo) begin
        route[7:0] <= pwdata[7:0];
      end
      if (hit_rte && wr_hi) begin
        route[ROUTE_W-1:8] <= pwdata[ROUTE_W-1:8];
      end
    end
  end

  // Divider for the repeat rate of level-mode timer events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_cnt <= '0;
    end else if (rep_cnt == REP_LAST) begin
      rep_cnt <= '0;
    end else begin
      rep_cnt <= rep_cnt + 1'b1;
    end
  end

  // APB answer: one wait state, then pready with data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc_first;
      pslverr <= acc_first & ~addr_hit;
      if (acc_first && !pwrite && addr_hit) begin
        prdata <= rd_data;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Requests, standby release and timer events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 8'h00;
      hold_release <= 1'b0;
      halt_on_rc <= 1'b0;
      t2_count <= 1'b0;
      t3_count <= 1'b0;
      t2l_capture <= 1'b0;
      t2h_capture <= 1'b0;
    end else begin
      irq_req <= req_now;
      hold_release <= standby_any & (|req_now);
      halt_on_rc <= standby_deep & (|req_now);
      t2_count <= route[RT_T2_EN] & cnt_evt[t2_src];
      t3_count <= route[RT_T3_EN] & cnt_evt[t3_src];
      t2l_capture <= route[RT_CAPL_EN] & cnt_evt[capl_src];
      t2h_capture <= route[RT_CAPH_EN] & cnt_evt[caph_src];
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire t2_lvl = route[RT_T2_EN] & lvl_act[t2_src];
  wire t3_lvl = route[RT_T3_EN] & lvl_act[t3_src];
  wire capl_lvl = route[RT_CAPL_EN] & lvl_act[capl_src];
  wire caph_lvl = route[RT_CAPH_EN] & lvl_act[caph_src];

  sequence s_held2(sig);
    sig [*2];
  endsequence

  AST_FLAG_ON_DETECT: assert property (|set_evt |=> (flag & $past(set_evt)) == $past(set_evt))
    else $error("Detected event did not set its flag");
  AST_SET_BEATS_CLEAR: assert property (set_evt[0] && wr_ctrl[0] && !pwdata[LOWER_FLAG_BIT]
    |=> flag[0])
    else $error("Flag lost when cleared in the detection cycle");
  AST_FLAG_STICKY: assert property (flag[2] && !wr_ctrl[1] |=> flag[2])
    else $error("Flag cleared without a write");
  AST_SYNC_TWO_STAGE: assert property ($past(presetn, 3) |-> pin_prev == $past(ext_irq_pin, 3))
    else $error("Pin history not three samples behind the pin");
  AST_T2_EDGE: assert property (route[RT_T2_EN] && edge_evt[t2_src] |=> t2_count)
    else $error("Timer 2 count missing after edge");
  AST_T2_LEVEL: assert property (s_held2(t2_lvl) |-> ##[0:1] t2_count)
    else $error("Timer 2 level count not repeated");
  AST_T3_EDGE: assert property (route[RT_T3_EN] && edge_evt[t3_src] |=> t3_count)
    else $error("Timer 3 count missing after edge");
  AST_T3_LEVEL: assert property (s_held2(t3_lvl) |-> ##[0:1] t3_count)
    else $error("Timer 3 level count not repeated");
  AST_CAPL_EDGE: assert property (route[RT_CAPL_EN] && edge_evt[capl_src] |=> t2l_capture)
    else $error("Timer 2L capture missing after edge");
  AST_CAPL_LEVEL: assert property (s_held2(capl_lvl) |-> ##[0:1] t2l_capture)
    else $error("Timer 2L capture not repeated");
  AST_CAPH_EDGE: assert property (route[RT_CAPH_EN] && edge_evt[caph_src] |=> t2h_capture)
    else $error("Timer 2H capture missing after edge");
  AST_CAPH_LEVEL: assert property (s_held2(caph_lvl) |-> ##[0:1] t2h_capture)
    else $error("Timer 2H capture not repeated");
  AST_WAKE_DEEP: assert property (standby_deep && (|req_now) |=> hold_release && halt_on_rc)
    else $error("Deep standby not released onto RC clock");
  AST_WAKE_KEEP: assert property (osc_keeping_standby && !standby_deep && (|req_now)
    |=> hold_release && !halt_on_rc)
    else $error("Oscillator-keeping standby release wrong");
  AST_LEVEL_IN_STANDBY: assert property (standby_any && lvl_act[6] |=> flag[6])
    else $error("Level input did not set flag in standby");
  AST_BLOCKED_EDGE: assert property (standby_any && !standby_entry && !flag[7] && !wr_ctrl[3]
    && mode[7] == MODE_FALL && pin_prev[7] != entry_lvl[7] |=> !flag[7])
    else $error("Edge toward entry level set the flag");
  AST_REQ_FOLLOWS: assert property (irq_req == $past(flag & en))
    else $error("Request does not follow flag and enable");
  AST_APB_ONE_WAIT: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer not one wait state");

endmodule
